/* File: logic/rdc_defs.svh */
// constants for the redriver configuration and receiver-detect control block
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH
`define RDC_CLK_KHZ      10000
`define RDC_POLL_US      150
`define RDC_POLL_CYC     ((`RDC_POLL_US * `RDC_CLK_KHZ) / 1000)
`define RDC_PDHOLD_US    200
`define RDC_PDHOLD_CYC   ((`RDC_PDHOLD_US * `RDC_CLK_KHZ + 999) / 1000)
`define RDC_SETTLE_CYC   3'h4
`define RDC_ADR_CTRL     4'h0
`define RDC_ADR_EQ_A     4'h1
`define RDC_ADR_EQ_B     4'h2
`define RDC_ADR_DET_CMD  4'h3
`define RDC_ADR_STATUS   4'h4
`define RDC_ADR_STRAPS   4'h5
`define RDC_CTRL_EQEN    0
`define RDC_CTRL_PDB     1
`define RDC_EQ_RST       4'h0
`define RDC_SADDR_M1     7'h18
`define RDC_SADDR_M2     7'h20
`endif

/* File: logic/rdc_pkg.sv */
// types shared by the redriver control block
package rdc_pkg;
  typedef enum logic [1:0] {
    RDC_L0 = 2'b00,
    RDC_L1 = 2'b01,
    RDC_L2 = 2'b10,
    RDC_L3 = 2'b11
  } rdc_lvl_t;
  typedef enum logic [1:0] {
    RDC_DET_IDLE  = 2'b00,
    RDC_DET_WAIT  = 2'b01,
    RDC_DET_PROBE = 2'b10,
    RDC_DET_FOUND = 2'b11
  } rdc_det_state_t;
endpackage

/* File: logic/rdc_strap_dec.sv */
// four-level strap resolver: synchronised comparator bits to a two-bit level
`timescale 1ns/1ps
module rdc_strap_dec (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_cmp,
  output logic      [1:0] o_level
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [1:0] level_d;
  // thermometer code: float reads highest, 1k to ground lowest
  assign level_d = sync_q[2] ? rdc_pkg::RDC_L3 :
                   sync_q[1] ? rdc_pkg::RDC_L2 :
                   sync_q[0] ? rdc_pkg::RDC_L1 : rdc_pkg::RDC_L0;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q  <= 3'h0;
      sync_q  <= 3'h0;
      o_level <= 2'h3;
    end else begin
      meta_q  <= i_cmp;
      sync_q  <= meta_q;
      o_level <= level_d;
    end
  end
endmodule

/* File: logic/rdc_det_chan.sv */
// receiver-detect poller for one channel
`timescale 1ns/1ps
module rdc_det_chan (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_start,
  input  wire logic i_tick,
  input  wire logic i_sense,
  output logic      o_detected,
  output logic      o_probe
);
  rdc_pkg::rdc_det_state_t state_q;
  rdc_pkg::rdc_det_state_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      rdc_pkg::RDC_DET_IDLE: state_d = rdc_pkg::RDC_DET_IDLE;
      rdc_pkg::RDC_DET_WAIT: begin
        if (i_tick) begin
          state_d = rdc_pkg::RDC_DET_PROBE;
        end
      end
      rdc_pkg::RDC_DET_PROBE: begin
        state_d = i_sense ? rdc_pkg::RDC_DET_FOUND : rdc_pkg::RDC_DET_WAIT;
      end
      rdc_pkg::RDC_DET_FOUND: state_d = rdc_pkg::RDC_DET_FOUND;
      default: state_d = rdc_pkg::RDC_DET_IDLE;
    endcase
    // a start clears any earlier result and polls afresh
    if (i_start) begin
      state_d = rdc_pkg::RDC_DET_WAIT;
    end
    if (!i_enable) begin
      state_d = rdc_pkg::RDC_DET_IDLE;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q    <= rdc_pkg::RDC_DET_IDLE;
      o_detected <= 1'b0;
      o_probe    <= 1'b0;
    end else begin
      state_q    <= state_d;
      o_detected <= (state_d == rdc_pkg::RDC_DET_FOUND);
      o_probe    <= (state_d == rdc_pkg::RDC_DET_PROBE);
    end
  end
endmodule

/* File: logic/rdc_ctl.sv */
// redriver strap decode, slave address, power-down and receiver-detect control
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "rdc_defs.svh"
// What this block does
// - pin mode index is four times hi plus lo
// - separate index per channel group
// - serial mode registers replace strap boost
// - pin mode gain follows gain strap
// - detect starts on powerup, pins, register
// - pin events all channels, register per channel
// - buffer level: detection off, 50 ohm unless powered down
// - float level: hi-z, poll, 50 ohm found
// - long power-down pulse restarts detection
// - power-down resets group a, hi-z
// - group b power-down resets, hi-z
// - float level gives active link mode
// - lowest level gives active buffer mode
// - each strap resolves to four levels
// - latch straps at powerup, mode live
// - serial modes enable bus configuration
// - slave addresses from address, mode straps
// - address table per mode, bank b plus one
// - pin mode needs no register access
module rdc_ctl #(
  parameter int unsigned POLL_CYC   = `RDC_POLL_CYC,
  parameter int unsigned PDHOLD_CYC = `RDC_PDHOLD_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_boost_sel_lo_cmp,
  input  wire logic [2:0] i_boost_sel_hi_cmp,
  input  wire logic [2:0] i_gain_cmp,
  input  wire logic [2:0] i_mode_cmp,
  input  wire logic [2:0] i_term_sense_cfg_cmp,
  input  wire logic [2:0] i_addr_cmp,
  input  wire logic       i_power_down_pin,
  input  wire logic       i_route_sel,
  input  wire logic [3:0] i_far_term,
  input  wire logic [3:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  output logic      [3:0] o_eq_idx_a,
  output logic      [3:0] o_eq_idx_b,
  output logic      [1:0] o_gain_lvl,
  output logic            o_serial_en,
  output logic      [6:0] o_slave_addr_a,
  output logic      [6:0] o_slave_addr_b,
  output logic            o_standby,
  output logic            o_link_mode,
  output logic            o_buffer_mode,
  output logic            o_path_rst_a,
  output logic            o_path_rst_b,
  output logic      [3:0] o_term_a,
  output logic      [3:0] o_term_b,
  output logic      [3:0] o_probe
);
  localparam int PW = $clog2(POLL_CYC);
  localparam int HW = $clog2(PDHOLD_CYC + 1);

  if (POLL_CYC < 16) begin : g_chk_poll
    $error("POLL_CYC too small");
  end
  if (PDHOLD_CYC < 2) begin : g_chk_hold
    $error("PDHOLD_CYC too small");
  end

  // ****************************************
  // strap resolution
  // ****************************************
  logic [1:0] lvl_lo;
  logic [1:0] lvl_hi;
  logic [1:0] lvl_gain;
  logic [1:0] lvl_mode;
  logic [1:0] lvl_det;
  logic [1:0] lvl_addr;

  rdc_strap_dec u_dec_lo   (.i_clk(i_clk), .i_rst(i_rst), .i_cmp(i_boost_sel_lo_cmp),
                            .o_level(lvl_lo));
  rdc_strap_dec u_dec_hi   (.i_clk(i_clk), .i_rst(i_rst), .i_cmp(i_boost_sel_hi_cmp),
                            .o_level(lvl_hi));
  rdc_strap_dec u_dec_gain (.i_clk(i_clk), .i_rst(i_rst), .i_cmp(i_gain_cmp),
                            .o_level(lvl_gain));
  rdc_strap_dec u_dec_mode (.i_clk(i_clk), .i_rst(i_rst), .i_cmp(i_mode_cmp),
                            .o_level(lvl_mode));
  rdc_strap_dec u_dec_det  (.i_clk(i_clk), .i_rst(i_rst), .i_cmp(i_term_sense_cfg_cmp),
                            .o_level(lvl_det));
  rdc_strap_dec u_dec_addr (.i_clk(i_clk), .i_rst(i_rst), .i_cmp(i_addr_cmp),
                            .o_level(lvl_addr));

  // ****************************************
  // power-up capture
  // ****************************************
  logic [2:0] settle_cnt_q;
  logic       captured_q;
  logic       captured_dly_q;
  logic [1:0] boost_lo_q;
  logic [1:0] boost_hi_q;
  logic [1:0] gain_q;
  logic [1:0] det_lvl_q;
  logic [1:0] addr_lvl_q;
  logic       capture;
  logic       pwrup_start;

  // waits out the synchroniser and decoder latency before trusting straps
  assign capture     = !captured_q && (settle_cnt_q == `RDC_SETTLE_CYC);
  assign pwrup_start = captured_q && !captured_dly_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      settle_cnt_q   <= 3'h0;
      captured_q     <= 1'b0;
      captured_dly_q <= 1'b0;
      boost_lo_q     <= 2'h0;
      boost_hi_q     <= 2'h0;
      gain_q         <= 2'h3;
      det_lvl_q      <= 2'h3;
      addr_lvl_q     <= 2'h0;
    end else begin
      captured_dly_q <= captured_q;
      if (!captured_q) begin
        settle_cnt_q <= settle_cnt_q + 3'h1;
      end
      if (capture) begin
        captured_q <= 1'b1;
        boost_lo_q <= lvl_lo;
        boost_hi_q <= lvl_hi;
        gain_q     <= lvl_gain;
        det_lvl_q  <= lvl_det;
        addr_lvl_q <= lvl_addr;
      end
    end
  end

  // ****************************************
  // pin synchronisers and events
  // ****************************************
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  logic [1:0] pin_prev_q;
  logic       pd;
  logic       sel_edge;
  logic       pd_fall;
  logic [HW-1:0] hold_cnt_q;
  logic       hold_ok;
  logic       pd_restart;

  assign pd         = pin_sync_q[0];
  assign sel_edge   = captured_q && (pin_sync_q[1] != pin_prev_q[1]);
  assign pd_fall    = pin_prev_q[0] && !pd;
  assign hold_ok    = (hold_cnt_q == HW'(PDHOLD_CYC));
  assign pd_restart = pd_fall && hold_ok;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
      pin_prev_q <= 2'h0;
      hold_cnt_q <= '0;
    end else begin
      pin_meta_q <= {i_far_term, i_route_sel, i_power_down_pin};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q[1:0];
      if (!pd) begin
        hold_cnt_q <= '0;
      end else if (!hold_ok) begin
        hold_cnt_q <= hold_cnt_q + HW'(1);
      end
    end
  end

  // ****************************************
  // register port
  // ****************************************
  logic       eqen_q;
  logic       pd_b_q;
  logic [3:0] eq_a_q;
  logic [3:0] eq_b_q;
  logic       serial;
  logic       wr_ok;
  logic       wr_ctrl;
  logic       wr_eq_a;
  logic       wr_eq_b;
  logic       wr_det;
  logic [3:0] det_vec;
  logic [3:0] pin_idx;
  logic [7:0] rd_mux;

  assign serial  = (lvl_mode == rdc_pkg::RDC_L1) || (lvl_mode == rdc_pkg::RDC_L2);
  // pin mode ignores writes so straps alone set the configuration
  assign wr_ok   = i_reg_wr && serial;
  assign wr_ctrl = wr_ok && (i_reg_addr == `RDC_ADR_CTRL);
  assign wr_eq_a = wr_ok && (i_reg_addr == `RDC_ADR_EQ_A);
  assign wr_eq_b = wr_ok && (i_reg_addr == `RDC_ADR_EQ_B);
  assign wr_det  = wr_ok && (i_reg_addr == `RDC_ADR_DET_CMD);
  assign pin_idx = {boost_hi_q, boost_lo_q};

  assign rd_mux =
    (i_reg_addr == `RDC_ADR_CTRL)   ? {6'h00, pd_b_q, eqen_q} :
    (i_reg_addr == `RDC_ADR_EQ_A)   ? {4'h0, eq_a_q} :
    (i_reg_addr == `RDC_ADR_EQ_B)   ? {4'h0, eq_b_q} :
    (i_reg_addr == `RDC_ADR_STATUS) ? {1'b0, pd, lvl_mode, det_vec} :
    (i_reg_addr == `RDC_ADR_STRAPS) ? {det_lvl_q, gain_q, pin_idx} : 8'h00;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      eqen_q      <= 1'b0;
      pd_b_q      <= 1'b0;
      eq_a_q      <= `RDC_EQ_RST;
      eq_b_q      <= `RDC_EQ_RST;
      o_reg_rdata <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        eqen_q <= i_reg_wdata[`RDC_CTRL_EQEN];
        pd_b_q <= i_reg_wdata[`RDC_CTRL_PDB];
      end
      if (wr_eq_a) begin
        eq_a_q <= i_reg_wdata[3:0];
      end
      if (wr_eq_b) begin
        eq_b_q <= i_reg_wdata[3:0];
      end
      o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // receiver detect
  // ****************************************
  logic [PW-1:0] poll_cnt_q;
  logic       poll_tick;
  logic       det_on;
  logic       buffer;
  logic       start_all;
  logic [3:0] det_start;
  logic [3:0] probe_vec;

  assign buffer    = (det_lvl_q == rdc_pkg::RDC_L0);
  assign det_on    = captured_q && !buffer;
  assign poll_tick = (poll_cnt_q == PW'(POLL_CYC - 1)) && !pd;
  assign start_all = pwrup_start || sel_edge || pd_restart;
  assign det_start = {4{start_all}} | (wr_det ? i_reg_wdata[3:0] : 4'h0);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      poll_cnt_q <= '0;
    end else if (pd || (poll_cnt_q == PW'(POLL_CYC - 1))) begin
      poll_cnt_q <= '0;
    end else begin
      poll_cnt_q <= poll_cnt_q + PW'(1);
    end
  end

  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    rdc_det_chan u_chan (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_enable   (det_on),
      .i_start    (det_start[ch]),
      .i_tick     (poll_tick),
      .i_sense    (pin_sync_q[2+ch]),
      .o_detected (det_vec[ch]),
      .o_probe    (probe_vec[ch])
    );
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [3:0] term_d;
  logic [6:0] addr_base;
  logic [6:0] addr_a_d;

  // buffer level never waits for a far end; link level shows hi-z until found
  assign term_d    = pd ? 4'h0 : (buffer ? 4'hf : det_vec);
  assign addr_base = (lvl_mode == rdc_pkg::RDC_L1) ? `RDC_SADDR_M1 : `RDC_SADDR_M2;
  assign addr_a_d  = addr_base + {4'h0, addr_lvl_q, 1'b0};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_eq_idx_a     <= 4'h0;
      o_eq_idx_b     <= 4'h0;
      o_gain_lvl     <= 2'h3;
      o_serial_en    <= 1'b0;
      o_slave_addr_a <= 7'h00;
      o_slave_addr_b <= 7'h00;
      o_standby      <= 1'b0;
      o_link_mode    <= 1'b0;
      o_buffer_mode  <= 1'b0;
      o_path_rst_a   <= 1'b1;
      o_path_rst_b   <= 1'b1;
      o_term_a       <= 4'h0;
      o_term_b       <= 4'h0;
      o_probe        <= 4'h0;
    end else begin
      o_eq_idx_a     <= (serial && eqen_q) ? eq_a_q : pin_idx;
      o_eq_idx_b     <= (serial && eqen_q) ? eq_b_q : pin_idx;
      o_gain_lvl     <= gain_q;
      o_serial_en    <= serial;
      o_slave_addr_a <= serial ? addr_a_d : 7'h00;
      o_slave_addr_b <= serial ? (addr_a_d | 7'h01) : 7'h00;
      o_standby      <= pd;
      o_link_mode    <= det_on && !pd;
      o_buffer_mode  <= captured_q && buffer && !pd;
      o_path_rst_a   <= pd;
      o_path_rst_b   <= pd || pd_b_q;
      o_term_a       <= term_d;
      o_term_b       <= pd_b_q ? 4'h0 : term_d;
      o_probe        <= probe_vec;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_no_tick;
    !poll_tick [*8];
  endsequence
  property p_pin_idx;
    (captured_dly_q && !(serial && eqen_q)) |=> (o_eq_idx_a == $past(pin_idx));
  endproperty
  a_pin_idx: assert property (p_pin_idx) else $error("pin index wrong");
  property p_grp_b;
    (serial && eqen_q) |=> (o_eq_idx_b == $past(eq_b_q));
  endproperty
  a_grp_b: assert property (p_grp_b) else $error("group b index wrong");
  property p_pin_nowr;
    (i_reg_wr && !serial) |=> $stable(eq_a_q) && $stable(eqen_q);
  endproperty
  a_pin_nowr: assert property (p_pin_nowr) else $error("write taken in pin mode");
  property p_restart;
    (start_all && det_on) |=> (det_vec == 4'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("detect not restarted");
  property p_buffer;
    (buffer && captured_q && !pd) |=> (o_term_a == 4'hf);
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer termination");
  property p_poll_gap;
    poll_tick |=> s_no_tick;
  endproperty
  a_poll_gap: assert property (p_poll_gap) else $error("poll too fast");
  property p_link_term;
    (det_on && !pd) |=> (o_term_a == $past(det_vec));
  endproperty
  a_link_term: assert property (p_link_term) else $error("link termination");
  property p_pd;
    pd |=> (o_path_rst_a && o_standby && (o_term_a == 4'h0));
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not applied");
  property p_pd_b;
    pd_b_q |=> (o_path_rst_b && (o_term_b == 4'h0));
  endproperty
  a_pd_b: assert property (p_pd_b) else $error("group b power-down");
  property p_latched;
    captured_q |=> $stable(boost_lo_q) && $stable(det_lvl_q);
  endproperty
  a_latched: assert property (p_latched) else $error("strap changed");
  property p_addr_m2;
    (lvl_mode == rdc_pkg::RDC_L2) |=> (o_slave_addr_b[6:3] == 4'h4) && o_slave_addr_b[0];
  endproperty
  a_addr_m2: assert property (p_addr_m2) else $error("slave address");
endmodule

/* File: tb/rdc_far_model.sv */
// far-end receiver model: shows termination on the plugged-in channels
`timescale 1ns/1ps
module rdc_far_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_present,
  output logic      [3:0] o_far_term
);
  logic [3:0] plug_q = 4'h0;
  // a fresh plug shows up one clock late, at the next rising edge after the present bit changes
  always @(posedge i_clk) begin
    plug_q <= i_present;
  end
  assign o_far_term = plug_q;
endmodule

/* File: tb/tb.sv */
// self-checking bench for the redriver control block
`timescale 1ns/1ps
module tb;
  localparam int unsigned POLL = 16;
  localparam int unsigned HOLD = 8;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [1:0] s_lo = 2'h0, s_hi = 2'h0, s_g = 2'h3, s_m = 2'h0, s_d = 2'h3, s_a = 2'h0;
  logic       i_power_down_pin = 1'b0;
  logic       i_route_sel = 1'b0;
  logic [3:0] present = 4'h0;
  logic [3:0] i_far_term;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic       i_reg_wr = 1'b0;
  logic       i_reg_rd = 1'b0;
  logic [7:0] o_reg_rdata;
  logic [3:0] o_eq_idx_a, o_eq_idx_b, o_term_a, o_term_b, o_probe;
  logic [1:0] o_gain_lvl;
  logic [6:0] o_slave_addr_a, o_slave_addr_b;
  logic       o_serial_en, o_standby, o_link_mode, o_buffer_mode, o_path_rst_a, o_path_rst_b;
  int         errors = 0;
  int         compares = 0;
  int         pcnt = 0;
  logic [31:0] seed = 32'ha7503c15;

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_probe[0] === 1'b1) pcnt++;

  rdc_far_model far (.i_clk(i_clk), .i_present(present), .o_far_term(i_far_term));

  rdc_ctl #(.POLL_CYC(POLL), .PDHOLD_CYC(HOLD)) dut (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_boost_sel_lo_cmp(therm(s_lo)), .i_boost_sel_hi_cmp(therm(s_hi)),
    .i_gain_cmp(therm(s_g)), .i_mode_cmp(therm(s_m)),
    .i_term_sense_cfg_cmp(therm(s_d)), .i_addr_cmp(therm(s_a)),
    .i_power_down_pin(i_power_down_pin), .i_route_sel(i_route_sel), .i_far_term(i_far_term),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_eq_idx_a(o_eq_idx_a),
    .o_eq_idx_b(o_eq_idx_b), .o_gain_lvl(o_gain_lvl), .o_serial_en(o_serial_en),
    .o_slave_addr_a(o_slave_addr_a), .o_slave_addr_b(o_slave_addr_b),
    .o_standby(o_standby), .o_link_mode(o_link_mode), .o_buffer_mode(o_buffer_mode),
    .o_path_rst_a(o_path_rst_a), .o_path_rst_b(o_path_rst_b), .o_term_a(o_term_a),
    .o_term_b(o_term_b), .o_probe(o_probe)
  );

  // ********************************
  // expectations and helpers
  // ********************************
  function automatic logic [2:0] therm(input logic [1:0] l);
    return (l == 2'h3) ? 3'h7 : (l == 2'h2) ? 3'h3 : (l == 2'h1) ? 3'h1 : 3'h0;
  endfunction
  function automatic logic [6:0] exp_addr(input logic [1:0] m, input logic [1:0] a,
                                          input logic b);
    if (m == 2'h1) return 7'h18 + {4'h0, a, b};
    if (m == 2'h2) return 7'h20 + {4'h0, a, b};
    return 7'h00;
  endfunction
  function automatic logic [31:0] rnd();
    logic [31:0] x;
    x = seed;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    seed = x;
    return x;
  endfunction
  task automatic cy(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic look();
    @(negedge i_clk);
  endtask
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    compares++;
    if (act !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic chk_bit(input logic act, input logic exp);
    compares++;
    if (act !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    d = o_reg_rdata;
  endtask
  // straps other than the live mode strap are only honoured at power-up, so every strap set needs a fresh reset
  task automatic power_up(input logic [1:0] lo, hi, g, m, d, a);
    @(posedge i_clk);
    {s_lo, s_hi, s_g, s_m, s_d, s_a} <= {lo, hi, g, m, d, a};
    i_rst <= 1'b1;
    cy(5);
    i_rst <= 1'b0;
    cy(15);
    look();
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end

  // ********************************
  // scenarios
  // ********************************
  initial begin
    logic [31:0] r;
    logic [1:0]  lo, hi, m, a, g, d;
    logic [7:0]  v, x;
    int          p;
    for (int i = 0; i < 64; i++) begin
      r = rnd();
      lo = i[1:0];
      hi = i[3:2];
      m = i[5:4];
      a = lo ^ hi;
      g = r[1:0];
      d = r[3:2];
      cy(1);
      present <= r[7:4];
      power_up(lo, hi, g, m, d, a);
      chk({4'h0, o_eq_idx_a}, {4'h0, hi, lo});
      chk({4'h0, o_eq_idx_b}, {4'h0, hi, lo});
      chk({6'h0, o_gain_lvl}, {6'h0, g});
      chk_bit(o_serial_en, m == 2'h1 || m == 2'h2);
      chk({1'b0, o_slave_addr_a}, {1'b0, exp_addr(m, a, 1'b0)});
      chk({1'b0, o_slave_addr_b}, {1'b0, exp_addr(m, a, 1'b1)});
      chk_bit(o_link_mode, d != 2'h0);
      chk_bit(o_buffer_mode, d == 2'h0);
      chk_bit(o_standby, 1'b0);
      if (d == 2'h0) chk({o_term_b, o_term_a}, 8'hff);
      rd(4'h5, v);
      chk(v, {d, g, hi, lo});
    end
    // mode strap stays live, boost straps do not
    cy(1);
    present <= 4'ha;
    power_up(2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1);
    cy(1);
    s_lo <= 2'h3;
    s_hi <= 2'h0;
    s_m <= 2'h2;
    cy(8);
    look();
    chk({4'h0, o_eq_idx_a}, 8'h09);
    chk_bit(o_serial_en, 1'b1);
    chk({1'b0, o_slave_addr_a}, 8'h22);
    r = rnd();
    x = r[7:0];
    wr(4'h0, 8'h01);
    wr(4'h1, {4'h0, x[3:0]});
    wr(4'h2, {4'h0, x[7:4]});
    cy(2);
    look();
    chk({4'h0, o_eq_idx_a}, {4'h0, x[3:0]});
    chk({4'h0, o_eq_idx_b}, {4'h0, x[7:4]});
    rd(4'h0, v);
    chk(v, 8'h01);
    rd(4'h3, v);
    chk(v, 8'h00);
    rd(4'hf, v);
    chk(v, 8'h00);
    wr(4'h5, 8'hff);
    rd(4'h5, v);
    chk(v, 8'hf9);
    cy(1);
    s_m <= 2'h0;
    cy(6);
    wr(4'h1, {4'h0, ~x[3:0]});
    cy(2);
    look();
    chk({4'h0, o_eq_idx_a}, 8'h09);
    cy(1);
    s_m <= 2'h2;
    cy(6);
    look();
    chk({4'h0, o_eq_idx_a}, {4'h0, x[3:0]});
    // ********************************
    // receiver detect
    // ********************************
    chk({o_term_b, o_term_a}, 8'haa);
    p = pcnt;
    cy(64);
    look();
    chk_bit((pcnt - p) >= 3 && (pcnt - p) <= 5, 1'b1);
    cy(1);
    present <= 4'hf;
    cy(50);
    look();
    chk({4'h0, o_term_a}, 8'h0f);
    cy(1);
    present <= 4'h0;
    wr(4'h3, 8'h03);
    cy(50);
    look();
    chk({o_term_b, o_term_a}, 8'hcc);
    rd(4'h4, v);
    chk(v, 8'h2c);
    look();
    chk(o_reg_rdata, 8'h00);
    cy(1);
    i_power_down_pin <= 1'b1;
    cy(5);
    look();
    chk_bit(o_standby, 1'b1);
    chk_bit(o_path_rst_a, 1'b1);
    chk_bit(o_path_rst_b, 1'b1);
    chk({o_term_b, o_term_a}, 8'h00);
    cy(1);
    i_power_down_pin <= 1'b0;
    cy(50);
    look();
    chk({4'h0, o_term_a}, 8'h0c);
    cy(1);
    i_power_down_pin <= 1'b1;
    cy(HOLD + 8);
    i_power_down_pin <= 1'b0;
    cy(50);
    look();
    chk({4'h0, o_term_a}, 8'h00);
    cy(1);
    present <= 4'h5;
    cy(50);
    look();
    chk({4'h0, o_term_a}, 8'h05);
    cy(1);
    present <= 4'h0;
    i_route_sel <= 1'b1;
    cy(50);
    look();
    chk({4'h0, o_term_a}, 8'h00);
    cy(1);
    present <= 4'hf;
    cy(50);
    wr(4'h0, 8'h03);
    cy(3);
    look();
    chk_bit(o_path_rst_b, 1'b1);
    chk_bit(o_path_rst_a, 1'b0);
    chk({o_term_b, o_term_a}, 8'h0f);
    wr(4'h0, 8'h01);
    cy(3);
    look();
    chk_bit(o_path_rst_b, 1'b0);
    tally_and_finish();
  end
endmodule
